/* bench/fpi_array_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fpi_array_model #(
  parameter int BUSY_CYCLES = 20
) (
  input  wire logic mclk_i,
  input  wire logic rst_i,
  input  wire logic erase_i,
  input  wire logic row_i,
  input  wire logic row_finish_i,
  output logic      op_done_o,
  output logic      row_end_o
);
  int cnt_r;

  ////////////////////////////////////////////////////////////////////////////
  // The array answers once per operation and then waits for the drop.
  // A row only reaches its last column when the bench asks for it.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r     <= 0;
      op_done_o <= 1'b0;
      row_end_o <= 1'b0;
    end else begin
      op_done_o <= 1'b0;
      row_end_o <= 1'b0;
      if (!(erase_i || row_i))
        cnt_r <= 0;
      else if (cnt_r < BUSY_CYCLES)
        cnt_r <= cnt_r + 1;
      if (cnt_r == BUSY_CYCLES - 1) begin
        op_done_o <= erase_i;
        row_end_o <= row_i && row_finish_i;
      end
    end
  end
endmodule
`default_nettype wire

/* bench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [7:0] prot_a = fpi_pkg::PROT_OFS;
  localparam logic [7:0] irq_a  = fpi_pkg::IRQ_OFS;
  localparam logic [7:0] page_a = fpi_pkg::PAGE_OFS;

  logic                            mclk_i = 1'b0;
  logic                            rst_i = 1'b1;
  fpi_pkg::fpi_io_type             io_s = '0;
  fpi_pkg::fpi_ctl_type            ctl_s;
  logic                            mass_set = 1'b0;
  logic                            page_set = 1'b0;
  logic                            row_set = 1'b0;
  logic                            wr_req = 1'b0;
  logic [fpi_pkg::ADDR_W-1:0]      wr_addr = '0;
  logic                            key_ok = 1'b0;
  logic                            row_finish = 1'b0;
  logic [fpi_pkg::FDIV_W-1:0]      fdiv = 8'h01;
  logic                            op_done;
  logic                            row_end;
  logic [7:0]                      rdata;
  logic                            mass_o;
  logic                            pg_o;
  logic                            row_o;
  logic                            info_o;
  logic [fpi_pkg::PAGE_W-1:0]      page_num;
  logic                            wgo;
  logic                            irq_d;
  logic                            irq_e;
  logic [fpi_pkg::PAGE_W-1:0]      page_s;
  logic                            wgo_s;
  logic [7:0]                      ops;
  int                              errors = 0;
  int                              checked = 0;

  always #2.5 mclk_i = ~mclk_i;
  assign ctl_s = {mass_set, page_set, row_set, op_done, row_end, wr_req,
                  wr_addr};
  assign ops = {5'h00, mass_o, pg_o, row_o};

  fpi_top #(.SMALL_MEM(1'b0)) dut (
    .mclk_i(mclk_i), .rst_i(rst_i), .io_i(io_s), .ctl_i(ctl_s),
    .key_unlocked_i(key_ok), .fdiv_i(fdiv), .io_rdata_o(rdata),
    .mass_erase_o(mass_o), .page_erase_start_o(pg_o),
    .row_program_start_o(row_o), .info_page_select_o(info_o),
    .page_o(page_num), .write_go_o(wgo), .irq_done_o(irq_d),
    .irq_err_o(irq_e));

  fpi_array_model #(.BUSY_CYCLES(20)) array (
    .mclk_i(mclk_i), .rst_i(rst_i), .erase_i(mass_o | pg_o),
    .row_i(row_o), .row_finish_i(row_finish), .op_done_o(op_done),
    .row_end_o(row_end));

  // Smaller variant fed the same stimulus; only its page and write gate
  // are watched.
  fpi_top #(.SMALL_MEM(1'b1)) dut_small (
    .mclk_i(mclk_i), .rst_i(rst_i), .io_i(io_s), .ctl_i(ctl_s),
    .key_unlocked_i(key_ok), .fdiv_i(fdiv), .io_rdata_o(),
    .mass_erase_o(), .page_erase_start_o(), .row_program_start_o(),
    .info_page_select_o(), .page_o(page_s), .write_go_o(wgo_s),
    .irq_done_o(), .irq_err_o());

  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string what);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    io_s.wr <= 1'b1;
    io_s.addr <= a;
    io_s.wdata <= d;
    @(posedge mclk_i);
    io_s.wr <= 1'b0;
    #1;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp,
                        input string what);
    @(posedge mclk_i);
    io_s.rd <= 1'b1;
    io_s.addr <= a;
    @(posedge mclk_i);
    io_s.rd <= 1'b0;
    #1;
    chk(rdata, exp, what);
  endtask

  // Bits of k are mass, page and row requests in that order.
  task automatic start_op(input logic [2:0] k, input logic [7:0] exp);
    @(posedge mclk_i);
    {mass_set, page_set, row_set} <= k;
    @(posedge mclk_i);
    {mass_set, page_set, row_set} <= 3'b000;
    #1;
    chk(ops, exp, "op start");
  endtask

  task automatic wait_idle(input int n);
    for (int i = 0; i < n && ops !== 8'h00; i++) begin
      @(posedge mclk_i);
      #1;
    end
    if (ops !== 8'h00) begin
      errors++;
      $display("BAD %0t operation never ended", $time);
      report_and_stop();
    end
  endtask

  task automatic flash_wr(input logic [16:0] a, input logic go);
    @(posedge mclk_i);
    wr_req <= 1'b1;
    wr_addr <= a;
    @(posedge mclk_i);
    wr_req <= 1'b0;
    #1;
    chk({7'h00, wgo}, {7'h00, go}, "write go");
  endtask

  task automatic set_key(input logic v);
    @(posedge mclk_i);
    key_ok <= v;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge mclk_i);
    errors++;
    $display("BAD %0t run did not finish", $time);
    report_and_stop();
  end

  initial begin
    repeat (4) @(posedge mclk_i);
    rst_i <= 1'b0;
    rd_reg(prot_a, 8'hff, "prot reset");
    rd_reg(irq_a, 8'h00, "irq reset");
    rd_reg(page_a, 8'h00, "page reset");
    rd_reg(8'hf0, 8'h00, "unmapped");
    $display("test reset done");
    set_key(1'b1);
    wr_reg(prot_a, 8'h5a);
    rd_reg(prot_a, 8'h5a, "unlocked write");
    set_key(1'b0);
    wr_reg(prot_a, 8'h00);
    rd_reg(prot_a, 8'hff, "locked write");
    $display("test protect lock done");
    wr_reg(irq_a, 8'h00);
    start_op(3'b100, 8'h00);
    chk({7'h00, irq_e}, 8'h00, "err irq masked");
    rd_reg(irq_a, 8'h01, "mass flag");
    wr_reg(irq_a, 8'hff);
    rd_reg(irq_a, 8'hc0, "enables only");
    start_op(3'b100, 8'h00);
    chk({7'h00, irq_e}, 8'h01, "err irq");
    rd_reg(irq_a, 8'hc1, "mass flag");
    chk({7'h00, irq_e}, 8'h00, "err irq drop");
    rd_reg(irq_a, 8'hc0, "read clears");
    $display("test mass refuse done");
    set_key(1'b1);
    wr_reg(prot_a, 8'h01);
    wr_reg(page_a, 8'h05);
    chk({info_o, page_num}, 8'h05, "page out");
    start_op(3'b010, 8'h00);
    rd_reg(irq_a, 8'hc2, "page flag");
    wr_reg(page_a, 8'h10);
    start_op(3'b010, 8'h02);
    wait_idle(100);
    chk({7'h00, irq_d}, 8'h01, "done irq");
    rd_reg(irq_a, 8'he0, "done flag");
    $display("test page erase done");
    wr_reg(page_a, 8'h85);
    chk({info_o, page_num}, 8'h85, "info out");
    start_op(3'b100, 8'h04);
    wait_idle(100);
    start_op(3'b010, 8'h02);
    wait_idle(100);
    rd_reg(irq_a, 8'he0, "info done");
    flash_wr(17'h00100, 1'b1);
    $display("test info page done");
    wr_reg(page_a, 8'h7f);
    chk({1'b0, page_s}, 8'h3f, "small page");
    wr_reg(page_a, 8'h00);
    flash_wr(17'h03fff, 1'b0);
    flash_wr(17'h04000, 1'b1);
    wr_reg(prot_a, 8'h80);
    flash_wr(17'h1c000, 1'b0);
    chk({7'h00, wgo_s}, 8'h01, "small block 7");
    flash_wr(17'h1bfff, 1'b1);
    rd_reg(irq_a, 8'hc8, "write flag");
    $display("test writes done");
    @(posedge mclk_i);
    row_finish <= 1'b1;
    start_op(3'b001, 8'h01);
    wait_idle(100);
    rd_reg(irq_a, 8'he0, "row done");
    @(posedge mclk_i);
    row_finish <= 1'b0;
    start_op(3'b001, 8'h01);
    repeat (2400) @(posedge mclk_i);
    #1;
    chk(ops, 8'h01, "row still on");
    wait_idle(40);
    rd_reg(irq_a, 8'hc4, "row timeout");
    @(posedge mclk_i);
    fdiv <= 8'h02;
    start_op(3'b001, 8'h01);
    repeat (4800) @(posedge mclk_i);
    #1;
    chk(ops, 8'h01, "slow row still on");
    wait_idle(80);
    rd_reg(irq_a, 8'hc4, "slow row timeout");
    $display("test row program done");
    report_and_stop();
  end
endmodule
`default_nettype wire

/* pkg/fpi_pkg.sv */
`default_nettype none
package fpi_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets, reset values and field positions.
  localparam logic [7:0] PROT_OFS    = 8'hfa;
  localparam logic [7:0] IRQ_OFS     = 8'hfb;
  localparam logic [7:0] PAGE_OFS    = 8'hfc;
  localparam logic [7:0] PROT_RST    = 8'hff;
  localparam logic [7:0] PROT_LOCKED = 8'hff;
  localparam logic [7:0] IRQ_RST     = 8'h00;
  localparam logic [7:0] PAGE_RST    = 8'h00;
  localparam logic [7:0] RDATA_RST   = 8'h00;
  localparam logic [7:0] UNMAPPED_RD = 8'h00;

  localparam int DONE_EN_BIT = 7;
  localparam int ERR_EN_BIT  = 6;
  localparam int DONE_BIT    = 5;
  localparam int WVIO_BIT    = 3;
  localparam int TMO_BIT     = 2;
  localparam int PVIO_BIT    = 1;
  localparam int MVIO_BIT    = 0;
  localparam logic [7:0] IRQ_WR_MASK  = 8'hc0;
  localparam logic [7:0] IRQ_RD_CLEAR = 8'h2f;
  localparam logic [7:0] ERR_MASK     = 8'h0f;

  localparam int INFO_BIT     = 7;
  localparam int PAGE_W       = 7;
  localparam int ADDR_W       = 17;
  localparam int ADDR_BLK_LSB = 14;
  localparam int PAGE_BLK_LSB = 4;
  localparam logic [7:0] SMALL_PROT_MASK = 8'h0f;
  localparam logic [7:0] SMALL_PAGE_MASK = 8'hbf;

  ////////////////////////////////////////////////////////////////////////////
  // Row program time-out, counted in controller clocks.
  localparam int              ROW_TMO_TICKS = 2432;
  localparam int              TMO_W         = 12;
  localparam logic [TMO_W-1:0] TMO_LAST     = 12'(ROW_TMO_TICKS - 1);
  localparam logic [TMO_W-1:0] TMO_RST      = 12'h000;
  localparam int              FDIV_W        = 8;
  localparam logic [FDIV_W-1:0] FDIV_CNT_RST = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers and module state.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fpi_io_type;

  typedef struct packed {
    logic              mass_set;
    logic              page_set;
    logic              row_set;
    logic              op_done;
    logic              row_end;
    logic              wr_req;
    logic [ADDR_W-1:0] wr_addr;
  } fpi_ctl_type;

  typedef struct packed {
    logic [7:0]       prot;
    logic [7:0]       irq;
    logic [7:0]       page;
    logic             mass;
    logic             page_erase_start;
    logic             row;
    logic [TMO_W-1:0] tmo_cnt;
    logic [7:0]       rdata;
    logic             wr_go;
    logic             irq_done;
    logic             irq_err;
  } fpi_state_type;

  typedef struct packed {
    logic [FDIV_W-1:0] cnt;
    logic              tick;
  } fpi_tick_state_type;

endpackage
`default_nettype wire

/* rtl/fpi_tick.sv */
`timescale 1ns/1ps
`default_nettype none
module fpi_tick #(
  parameter int DIV_W = 8
) (
  input  wire logic             mclk_i,
  input  wire logic             rst_i,
  input  wire logic             run_i,
  input  wire logic [DIV_W-1:0] div_i,
  output logic                  tick_o
);

  fpi_pkg::fpi_tick_state_type st_r;
  fpi_pkg::fpi_tick_state_type st_nxt;

  // One pulse every div_i system clocks; a zero divider acts as one.
  always_comb begin
    st_nxt      = st_r;
    st_nxt.tick = 1'b0;
    if (!run_i) begin
      st_nxt.cnt = fpi_pkg::FDIV_CNT_RST;
    end else if (st_r.cnt + 8'h01 >= div_i) begin
      st_nxt.cnt  = fpi_pkg::FDIV_CNT_RST;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 8'h01;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick_o = st_r.tick;

endmodule
`default_nettype wire

/* rtl/fpi_top.sv */
// Overview of operation
// - Any protect bit in use (only bits 3..0 in small variant) refuses mass erase unless the information page is selected.
// - Information page has no protection bit.
// - Protect register writable only after key unlock.
// - Locked protect write forces all ones.
// - Bit n guards 16 KB block n.
// - Small variant ignores protect bits 7..4.
// - Done and error interrupts, separately enabled.
// - Row program aborts after 2432 controller clocks.
// - Write to protected block suppressed, flagged.
// - Protected page erase refused, flagged.
// - Mass erase with protection refused, flagged, except with information page selected.
// - Error enable routes four error flags.
// - Completion sets done flag, done enable.
// - Interrupt register read clears flags.
// - Select bit steers to information page.
// - Information page erases spare main array.
// - Page field picks one of 128 pages, 64 in small variant.
// - Page field ignored with information page.
// - Erase control bits clear when finished.
// - Time-out clock divided from system clock.
`timescale 1ns/1ps
`default_nettype none
module fpi_top #(
  parameter bit SMALL_MEM = 1'b0
) (
  input  wire logic                      mclk_i,
  input  wire logic                      rst_i,
  input  wire fpi_pkg::fpi_io_type       io_i,
  input  wire fpi_pkg::fpi_ctl_type      ctl_i,
  input  wire logic                      key_unlocked_i,
  input  wire logic [fpi_pkg::FDIV_W-1:0] fdiv_i,
  output logic [7:0]                     io_rdata_o,
  output logic                           mass_erase_o,
  output logic                           page_erase_start_o,
  output logic                           row_program_start_o,
  output logic                           info_page_select_o,
  output logic [fpi_pkg::PAGE_W-1:0]     page_o,
  output logic                           write_go_o,
  output logic                           irq_done_o,
  output logic                           irq_err_o
);

  fpi_pkg::fpi_state_type st_r;
  fpi_pkg::fpi_state_type st_nxt;
  logic                   tick;
  logic [7:0]             prot_eff;
  logic                   busy;
  logic                   info_sel;
  logic                   wr_blocked;
  logic                   pg_blocked;
  logic                   mass_blocked;

  ////////////////////////////////////////////////////////////////////////////
  // Controller clock for the row program time-out.

  fpi_tick #(
    .DIV_W (fpi_pkg::FDIV_W)
  ) u_tick (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .run_i  (st_r.row),
    .div_i  (fdiv_i),
    .tick_o (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Protection decode.

  assign prot_eff = SMALL_MEM ? (st_r.prot & fpi_pkg::SMALL_PROT_MASK)
                              : st_r.prot;
  assign info_sel = st_r.page[fpi_pkg::INFO_BIT];
  assign busy     = st_r.mass | st_r.page_erase_start | st_r.row;

  assign wr_blocked = !info_sel &&
    prot_eff[ctl_i.wr_addr[fpi_pkg::ADDR_BLK_LSB +: 3]];
  assign pg_blocked = !info_sel &&
    prot_eff[st_r.page[fpi_pkg::PAGE_BLK_LSB +: 3]];
  assign mass_blocked = !info_sel && (prot_eff != 8'h00);

  ////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    st_nxt       = st_r;
    st_nxt.wr_go = 1'b0;

    // Register writes and the clear-on-read come first so that events
    // raised in the same cycle override them.
    if (io_i.wr) begin
      case (io_i.addr)
        fpi_pkg::PROT_OFS: begin
          st_nxt.prot = key_unlocked_i ? io_i.wdata : fpi_pkg::PROT_LOCKED;
        end
        fpi_pkg::IRQ_OFS: begin
          st_nxt.irq = (st_r.irq & ~fpi_pkg::IRQ_WR_MASK) |
                       (io_i.wdata & fpi_pkg::IRQ_WR_MASK);
        end
        fpi_pkg::PAGE_OFS: begin
          st_nxt.page = SMALL_MEM ? (io_i.wdata & fpi_pkg::SMALL_PAGE_MASK)
                                  : io_i.wdata;
        end
        default: begin
        end
      endcase
    end

    if (io_i.rd) begin
      case (io_i.addr)
        fpi_pkg::PROT_OFS: st_nxt.rdata = st_r.prot;
        fpi_pkg::IRQ_OFS: begin
          st_nxt.rdata = st_r.irq;
          st_nxt.irq   = st_nxt.irq & ~fpi_pkg::IRQ_RD_CLEAR;
        end
        fpi_pkg::PAGE_OFS: st_nxt.rdata = st_r.page;
        default:           st_nxt.rdata = fpi_pkg::UNMAPPED_RD;
      endcase
    end

    // Erase and row program requests are taken only while idle; the array is single-ported.
    if (!busy) begin
      if (ctl_i.mass_set) begin
        if (mass_blocked) begin
          st_nxt.irq[fpi_pkg::MVIO_BIT] = 1'b1;
        end else begin
          st_nxt.mass = 1'b1;
        end
      end else if (ctl_i.page_set) begin
        if (pg_blocked) begin
          st_nxt.irq[fpi_pkg::PVIO_BIT] = 1'b1;
        end else begin
          st_nxt.page_erase_start = 1'b1;
        end
      end else if (ctl_i.row_set) begin
        st_nxt.row     = 1'b1;
        st_nxt.tmo_cnt = fpi_pkg::TMO_RST;
      end
    end else if (ctl_i.op_done || (st_r.row && ctl_i.row_end)) begin
      st_nxt.mass                   = 1'b0;
      st_nxt.page_erase_start               = 1'b0;
      st_nxt.row                    = 1'b0;
      st_nxt.irq[fpi_pkg::DONE_BIT] = 1'b1;
    end else if (st_r.row && tick) begin
      if (st_r.tmo_cnt == fpi_pkg::TMO_LAST) begin
        st_nxt.row                   = 1'b0;
        st_nxt.irq[fpi_pkg::TMO_BIT] = 1'b1;
      end else begin
        st_nxt.tmo_cnt = st_r.tmo_cnt + 12'h001;
      end
    end

    if (ctl_i.wr_req) begin
      if (wr_blocked) begin
        st_nxt.irq[fpi_pkg::WVIO_BIT] = 1'b1;
      end else begin
        st_nxt.wr_go = 1'b1;
      end
    end

    st_nxt.irq_err  = st_nxt.irq[fpi_pkg::ERR_EN_BIT] &&
                      ((st_nxt.irq & fpi_pkg::ERR_MASK) != 8'h00);
    st_nxt.irq_done = st_nxt.irq[fpi_pkg::DONE_EN_BIT] &&
                      st_nxt.irq[fpi_pkg::DONE_BIT];
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r          <= '0;
      st_r.prot     <= fpi_pkg::PROT_RST;
      st_r.irq      <= fpi_pkg::IRQ_RST;
      st_r.page     <= fpi_pkg::PAGE_RST;
      st_r.tmo_cnt  <= fpi_pkg::TMO_RST;
      st_r.rdata    <= fpi_pkg::RDATA_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign io_rdata_o          = st_r.rdata;
  assign mass_erase_o        = st_r.mass;
  assign page_erase_start_o  = st_r.page_erase_start;
  assign row_program_start_o = st_r.row;
  assign info_page_select_o  = st_r.page[fpi_pkg::INFO_BIT];
  assign page_o              = st_r.page[fpi_pkg::PAGE_W-1:0];
  assign write_go_o          = st_r.wr_go;
  assign irq_done_o          = st_r.irq_done;
  assign irq_err_o           = st_r.irq_err;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  logic prot_wr;
  logic irq_rd;
  assign prot_wr = io_i.wr && io_i.addr == fpi_pkg::PROT_OFS;
  assign irq_rd  = io_i.rd && io_i.addr == fpi_pkg::IRQ_OFS;

  sequence seq_row_expire;
    row_program_start_o && tick && !ctl_i.op_done && !ctl_i.row_end &&
    st_r.tmo_cnt == fpi_pkg::TMO_LAST;
  endsequence

  sequence seq_row_aborted;
    !row_program_start_o && st_r.irq[fpi_pkg::TMO_BIT] &&
    !$rose(st_r.irq[fpi_pkg::DONE_BIT]);
  endsequence

  mass_refuse_a: assert property (
    !busy && ctl_i.mass_set && !info_sel && prot_eff != 8'h00
    |=> !mass_erase_o && st_r.irq[fpi_pkg::MVIO_BIT] ##1 !mass_erase_o)
    else $error("mass erase started while blocks protected");

  prot_unlock_a: assert property (
    prot_wr && key_unlocked_i |=> st_r.prot == $past(io_i.wdata))
    else $error("unlocked protect write not stored");

  prot_lock_a: assert property (
    prot_wr && !key_unlocked_i |=> st_r.prot == fpi_pkg::PROT_LOCKED)
    else $error("locked protect write did not force all ones");

  write_guard_a: assert property (
    ctl_i.wr_req && !info_sel &&
    prot_eff[ctl_i.wr_addr[fpi_pkg::ADDR_BLK_LSB +: 3]]
    |=> !write_go_o && st_r.irq[fpi_pkg::WVIO_BIT])
    else $error("write to protected block not suppressed");

  info_write_a: assert property (
    ctl_i.wr_req && info_page_select_o |=> write_go_o)
    else $error("information page write was blocked");

  page_guard_a: assert property (
    !busy && !ctl_i.mass_set && ctl_i.page_set && pg_blocked
    |=> !page_erase_start_o && st_r.irq[fpi_pkg::PVIO_BIT])
    else $error("protected page erase started");

  row_timeout_a: assert property (
    seq_row_expire |=> seq_row_aborted)
    else $error("row program time-out not taken");

  erase_done_a: assert property (
    page_erase_start_o && ctl_i.op_done
    |=> !page_erase_start_o && st_r.irq[fpi_pkg::DONE_BIT])
    else $error("page erase bit did not clear on completion");

  read_clear_a: assert property (
    irq_rd && !io_i.wr && !ctl_i.wr_req && !ctl_i.op_done &&
    !ctl_i.mass_set && !ctl_i.page_set && !ctl_i.row_end &&
    !(row_program_start_o && tick)
    |=> (st_r.irq & fpi_pkg::IRQ_RD_CLEAR) == 8'h00 &&
        $stable(st_r.irq[7:6]))
    else $error("interrupt read did not clear flags");

  err_irq_a: assert property (
    $rose(st_r.irq[fpi_pkg::TMO_BIT]) && st_r.irq[fpi_pkg::ERR_EN_BIT]
    |-> irq_err_o)
    else $error("error flag with enable gave no interrupt");

  done_irq_a: assert property (
    irq_done_o |-> st_r.irq[fpi_pkg::DONE_BIT] &&
                   st_r.irq[fpi_pkg::DONE_EN_BIT])
    else $error("done interrupt without enabled done flag");

  small_mask_a: assert property (
    SMALL_MEM |-> prot_eff[7:4] == 4'h0 && !page_o[6])
    else $error("small variant uses absent blocks");

endmodule
`default_nettype wire
